// ### logic/sysrst_ctrl.sv
// System reset controller: sources, state manager, pin shaping, registers
// Functional notes
// - Pin is sampled on slow clock; low reports a user reset request.
// - With user reset disabled, a low pin causes no user reset.
// - User reset flag sets on pin falling; cleared only by status read.
// - Pin level is always readable in the status register.
// - User reset interrupt enable raises interrupt only while user reset is disabled.
// - External pulse lasts 2^(length+1) slow cycles; length 0 gives two.
// - Brownout with reset disabled only sets a read-cleared brownout flag.
// - Brownout interrupt enable lets brownout flag raise the interrupt.
// - Last reset type updates only when the processor reset releases.
// - Startup counter on slow clock filters power-up, then records power-up.
// - Low core supply asserts all reset outputs at once, clocklessly.
// - Low pin with user reset enabled asserts processor and peripheral resets.
// - User reset ends after pin rise, resync and startup; type 0x4.
// - Pin held low externally keeps internal resets until it rises.
// - Brownout asserts all resets; release 3+2 slow cycles later, type 0x5.
// - Software may request cpu, peripheral, pin resets in any combination.
// - Commanded cpu and peripheral resets assert on the write; last 3 slow cycles.
// - Self-driven pin pulses never enter user reset.
// - Software type recorded only when the cpu reset bit was set.
// - Command-in-progress flag spans software reset; control writes then ignored.
// - Control writes act only with password 0xA5.
// - Types: power-up 000, watchdog 010, software 011, user 100, brownout 101.
// - Priority: power-up, brownout, watchdog, software, user.
module sysrst_ctrl #(
  parameter int unsigned SLOW_DIV = sysrst_pkg::SLOW_DIV,
  parameter int unsigned STARTUP_SLOW = sysrst_pkg::STARTUP_SLOW
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic core_supply_ok,
  input wire logic brownout_det,
  input wire logic brownout_rst_en,
  input wire logic wdog_fault,
  input wire logic ext_pin_in,
  output logic ext_pin_out,
  output logic ext_pin_oe,
  output logic cpu_nreset,
  output logic periph_nreset,
  output logic irq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  sysrst_pkg::sysrst_state_t state_r, state_nxt;
  logic [15:0] div_r;
  logic slow_en;
  logic [15:0] start_cnt_r;
  logic [2:0] hold_cnt_r;
  logic [16:0] ext_cnt_r;
  logic [2:0] guard_r;
  logic pin_m, pin_s, pin_s_d, pin_slow_r;
  logic sup_m, sup_s, bod_m, bod_s, bod_s_d, boden_m, boden_s;
  logic user_en_r, user_ien_r, brown_ien_r;
  logic [3:0] ext_len_r;
  logic user_flag_r, brown_flag_r;
  logic [2:0] type_r, pend_type_r;
  logic cmd_cpu_r, cmd_periph_r;
  logic cpu_n_r, periph_n_r;
  logic ctl_wr, key_ok, status_rd, ext_start, self_drive, bod_active;
  logic cpu_assert, periph_assert;

  // Slow clock enable from the system clock divider
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) div_r <= 16'h0000;
    else if (slow_en) div_r <= 16'h0000;
    else div_r <= div_r + 16'h0001;
  end
  assign slow_en = (div_r == 16'(SLOW_DIV - 1));

  // Two-stage synchronisers for every pin input
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_m <= 1'b1;
      pin_s <= 1'b1;
      pin_s_d <= 1'b1;
      sup_m <= 1'b0;
      sup_s <= 1'b0;
      bod_m <= 1'b0;
      bod_s <= 1'b0;
      bod_s_d <= 1'b0;
      boden_m <= 1'b0;
      boden_s <= 1'b0;
    end
    else
    begin
      pin_m <= ext_pin_in;
      pin_s <= pin_m;
      pin_s_d <= pin_s;
      sup_m <= core_supply_ok;
      sup_s <= sup_m;
      bod_m <= brownout_det;
      bod_s <= bod_m;
      bod_s_d <= bod_s;
      boden_m <= brownout_rst_en;
      boden_s <= boden_m;
    end
  end

  // Pin level as seen by the state manager, taken on slow ticks only
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) pin_slow_r <= 1'b1;
    else if (slow_en) pin_slow_r <= pin_s;
  end

  // Register bus decode
  assign ctl_wr = reg_wr && (reg_addr == sysrst_pkg::OFS_CONTROL);
  assign key_ok = (reg_wdata[sysrst_pkg::KEY_LSB +: 8] == sysrst_pkg::KEY_VALUE);
  assign status_rd = reg_rd && (reg_addr == sysrst_pkg::OFS_STATUS);
  assign bod_active = bod_s && boden_s;

  // Mode register; password guarded like the control register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      user_en_r <= 1'b0;
      user_ien_r <= 1'b0;
      brown_ien_r <= 1'b0;
      ext_len_r <= sysrst_pkg::MR_LEN_RESET;
    end
    else if (reg_wr && reg_addr == sysrst_pkg::OFS_MODE && key_ok)
    begin
      user_en_r <= reg_wdata[sysrst_pkg::MR_USER_EN];
      user_ien_r <= reg_wdata[sysrst_pkg::MR_USER_IRQ_EN];
      brown_ien_r <= reg_wdata[sysrst_pkg::MR_BROWN_IRQ_EN];
      ext_len_r <= reg_wdata[sysrst_pkg::MR_LEN_LSB +: 4];
    end
  end

  // Sticky flags; a new event wins over the clearing status read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      user_flag_r <= 1'b0;
      brown_flag_r <= 1'b0;
    end
    else
    begin
      if (pin_s_d && !pin_s) user_flag_r <= 1'b1;
      else if (status_rd) user_flag_r <= 1'b0;
      if (bod_s && !bod_s_d && !boden_s) brown_flag_r <= 1'b1;
      else if (status_rd) brown_flag_r <= 1'b0;
    end
  end

  // Reset state manager, sources checked in priority order
  always_comb
  begin
    state_nxt = state_r;
    if (!sup_s) state_nxt = sysrst_pkg::SYSRST_STARTUP;
    else if (bod_active && state_r != sysrst_pkg::SYSRST_STARTUP)
      state_nxt = sysrst_pkg::SYSRST_BROWN;
    else
    begin
      case (state_r)
        sysrst_pkg::SYSRST_STARTUP:
          if (slow_en && start_cnt_r == 16'(STARTUP_SLOW - 1))
            state_nxt = sysrst_pkg::SYSRST_IDLE;
        sysrst_pkg::SYSRST_IDLE:
          if (wdog_fault) state_nxt = sysrst_pkg::SYSRST_WDOG;
          else if (ctl_wr && key_ok && reg_wdata[3:0] != 4'h0
                   && (reg_wdata[sysrst_pkg::CR_CPU] || reg_wdata[sysrst_pkg::CR_PERIPH]
                       || reg_wdata[sysrst_pkg::CR_PIN]))
            state_nxt = sysrst_pkg::SYSRST_SOFT;
          else if (slow_en && !pin_slow_r && user_en_r && !self_drive)
            state_nxt = sysrst_pkg::SYSRST_USER;
        sysrst_pkg::SYSRST_USER:
          if (slow_en && pin_slow_r && hold_cnt_r == sysrst_pkg::LEAVE_SLOW - 3'h1)
            state_nxt = sysrst_pkg::SYSRST_IDLE;
        sysrst_pkg::SYSRST_BROWN:
          if (slow_en && hold_cnt_r == sysrst_pkg::LEAVE_SLOW - 3'h1)
            state_nxt = sysrst_pkg::SYSRST_IDLE;
        sysrst_pkg::SYSRST_WDOG:
          if (slow_en && hold_cnt_r == sysrst_pkg::HOLD_SLOW - 3'h1)
            state_nxt = sysrst_pkg::SYSRST_IDLE;
        sysrst_pkg::SYSRST_SOFT:
          if (wdog_fault) state_nxt = sysrst_pkg::SYSRST_WDOG;
          else if (slow_en && hold_cnt_r == sysrst_pkg::HOLD_SLOW - 3'h1)
            state_nxt = sysrst_pkg::SYSRST_IDLE;
        default: state_nxt = sysrst_pkg::SYSRST_STARTUP;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) state_r <= sysrst_pkg::SYSRST_STARTUP;
    else state_r <= state_nxt;
  end

  // Startup filter counter on slow ticks; cleared while supply is low
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) start_cnt_r <= 16'h0000;
    else if (state_r != sysrst_pkg::SYSRST_STARTUP || !sup_s) start_cnt_r <= 16'h0000;
    else if (slow_en) start_cnt_r <= start_cnt_r + 16'h0001;
  end

  // Dwell counter; restarts while the pin is still low or the brownout is still present
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) hold_cnt_r <= 3'h0;
    else if (state_nxt != state_r) hold_cnt_r <= 3'h0;
    else if (state_r == sysrst_pkg::SYSRST_USER && !pin_slow_r) hold_cnt_r <= 3'h0;
    else if (state_r == sysrst_pkg::SYSRST_BROWN && bod_active) hold_cnt_r <= 3'h0;
    else if (slow_en) hold_cnt_r <= hold_cnt_r + 3'h1;
  end

  // Latched software command bits for the life of the software reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_cpu_r <= 1'b0;
      cmd_periph_r <= 1'b0;
    end
    else if (state_r != sysrst_pkg::SYSRST_SOFT && state_nxt == sysrst_pkg::SYSRST_SOFT)
    begin
      cmd_cpu_r <= reg_wdata[sysrst_pkg::CR_CPU];
      cmd_periph_r <= reg_wdata[sysrst_pkg::CR_PERIPH];
    end
  end

  // External pulse starts on brownout, watchdog or a pin command
  assign ext_start = (state_r != state_nxt) &&
    ((state_nxt == sysrst_pkg::SYSRST_BROWN) || (state_nxt == sysrst_pkg::SYSRST_WDOG) ||
     (state_nxt == sysrst_pkg::SYSRST_SOFT && reg_wdata[sysrst_pkg::CR_PIN]));

  // Pulse shaper; counts slow ticks down from a power of two
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) ext_cnt_r <= 17'h0_0000;
    else if (ext_start) ext_cnt_r <= 17'h0_0002 << ext_len_r;
    else if (slow_en && ext_cnt_r != 17'h0_0000) ext_cnt_r <= ext_cnt_r - 17'h0_0001;
  end

  // Guard window covers the pin's rise back through the synchroniser
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) guard_r <= 3'h0;
    else if (ext_cnt_r != 17'h0_0000) guard_r <= 3'h3;
    else if (slow_en && guard_r != 3'h0) guard_r <= guard_r - 3'h1;
  end
  assign self_drive = (ext_cnt_r != 17'h0_0000) || (guard_r != 3'h0);

  // Open drain: only ever pulls low
  assign ext_pin_out = 1'b0;
  assign ext_pin_oe = (ext_cnt_r != 17'h0_0000) || !core_supply_ok;

  // Reset levels wanted in the next state
  always_comb
  begin
    cpu_assert = 1'b0;
    periph_assert = 1'b0;
    case (state_nxt)
      sysrst_pkg::SYSRST_STARTUP, sysrst_pkg::SYSRST_USER, sysrst_pkg::SYSRST_BROWN,
      sysrst_pkg::SYSRST_WDOG:
      begin
        cpu_assert = 1'b1;
        periph_assert = 1'b1;
      end
      sysrst_pkg::SYSRST_SOFT:
      begin
        cpu_assert = (state_r == sysrst_pkg::SYSRST_SOFT) ? cmd_cpu_r
                     : reg_wdata[sysrst_pkg::CR_CPU];
        periph_assert = (state_r == sysrst_pkg::SYSRST_SOFT) ? cmd_periph_r
                        : reg_wdata[sysrst_pkg::CR_PERIPH];
      end
      default:
      begin
        cpu_assert = 1'b0;
        periph_assert = 1'b0;
      end
    endcase
  end

  // Registered reset lines
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cpu_n_r <= 1'b0;
      periph_n_r <= 1'b0;
    end
    else
    begin
      cpu_n_r <= !cpu_assert;
      periph_n_r <= !periph_assert;
    end
  end

  // Supply loss overrides the flops with no clock involved
  assign cpu_nreset = cpu_n_r && core_supply_ok;
  assign periph_nreset = periph_n_r && core_supply_ok;

  // Cause noted on entry, published on processor release only
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) pend_type_r <= sysrst_pkg::TYPE_POWERUP;
    else if (state_nxt != state_r)
    begin
      case (state_nxt)
        sysrst_pkg::SYSRST_STARTUP: pend_type_r <= sysrst_pkg::TYPE_POWERUP;
        sysrst_pkg::SYSRST_USER: pend_type_r <= sysrst_pkg::TYPE_USER;
        sysrst_pkg::SYSRST_BROWN: pend_type_r <= sysrst_pkg::TYPE_BROWNOUT;
        sysrst_pkg::SYSRST_WDOG: pend_type_r <= sysrst_pkg::TYPE_WATCHDOG;
        sysrst_pkg::SYSRST_SOFT: pend_type_r <= sysrst_pkg::TYPE_SOFTWARE;
        default: pend_type_r <= pend_type_r;
      endcase
    end
  end

  // A command without the cpu bit never asserts cpu reset, so no update
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) type_r <= sysrst_pkg::TYPE_POWERUP;
    else if (!cpu_n_r && !cpu_assert) type_r <= pend_type_r;
  end

  // Interrupt; user flag only counts while user reset is disabled
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) irq <= 1'b0;
    else irq <= (user_flag_r && user_ien_r && !user_en_r)
                || (brown_flag_r && brown_ien_r);
  end

  // Read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_addr == sysrst_pkg::OFS_STATUS)
      begin
        reg_rdata[sysrst_pkg::SR_USER_FLAG] <= user_flag_r;
        reg_rdata[sysrst_pkg::SR_BROWN_FLAG] <= brown_flag_r;
        reg_rdata[sysrst_pkg::SR_TYPE_LSB +: 3] <= type_r;
        reg_rdata[sysrst_pkg::SR_PIN_LEVEL] <= pin_s;
        reg_rdata[sysrst_pkg::SR_IN_PROG] <= (state_r == sysrst_pkg::SYSRST_SOFT);
      end
      else if (reg_addr == sysrst_pkg::OFS_MODE)
      begin
        reg_rdata[sysrst_pkg::MR_USER_EN] <= user_en_r;
        reg_rdata[sysrst_pkg::MR_USER_IRQ_EN] <= user_ien_r;
        reg_rdata[sysrst_pkg::MR_LEN_LSB +: 4] <= ext_len_r;
        reg_rdata[sysrst_pkg::MR_BROWN_IRQ_EN] <= brown_ien_r;
      end
    end
  end
endmodule // sysrst_ctrl

// ### logic/sysrst_pkg.sv
// Constants shared by the system reset controller
package sysrst_pkg;
  // Clock rates and the slow clock enable divider
  localparam int unsigned SYS_CLK_HZ = 10000000;
  localparam int unsigned SLOW_CLK_HZ = 32768;
  localparam int unsigned SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;
  localparam int unsigned STARTUP_SLOW = 64;
  // Slow cycles of a software or watchdog reset
  localparam logic [2:0] HOLD_SLOW = 3'h3;
  // Resync plus processor startup after a source goes away
  localparam logic [2:0] LEAVE_SLOW = 3'h5;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  // Password field
  localparam int KEY_LSB = 24;
  localparam logic [7:0] KEY_VALUE = 8'hA5;
  // Control register bits
  localparam int CR_CPU = 0;
  localparam int CR_PERIPH = 2;
  localparam int CR_PIN = 3;
  // Status register fields
  localparam int SR_USER_FLAG = 0;
  localparam int SR_BROWN_FLAG = 1;
  localparam int SR_TYPE_LSB = 8;
  localparam int SR_PIN_LEVEL = 16;
  localparam int SR_IN_PROG = 17;
  // Mode register fields
  localparam int MR_USER_EN = 0;
  localparam int MR_USER_IRQ_EN = 4;
  localparam int MR_LEN_LSB = 8;
  localparam int MR_BROWN_IRQ_EN = 16;
  localparam logic [3:0] MR_LEN_RESET = 4'h0;
  // Last reset type codes
  localparam logic [2:0] TYPE_POWERUP = 3'h0;
  localparam logic [2:0] TYPE_WATCHDOG = 3'h2;
  localparam logic [2:0] TYPE_SOFTWARE = 3'h3;
  localparam logic [2:0] TYPE_USER = 3'h4;
  localparam logic [2:0] TYPE_BROWNOUT = 3'h5;
  // Reset state manager states
  typedef enum logic [2:0] {
    SYSRST_STARTUP = 3'b000,
    SYSRST_IDLE = 3'b001,
    SYSRST_USER = 3'b010,
    SYSRST_BROWN = 3'b011,
    SYSRST_WDOG = 3'b100,
    SYSRST_SOFT = 3'b101
  } sysrst_state_t;
endpackage

// ### sim/sysrst_ctrl_assertions.sv
// Port-level checks of the system reset controller
module sysrst_chk #(
  parameter int unsigned SLOW_DIV = 4,
  parameter int unsigned STARTUP_SLOW = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic core_supply_ok,
  input wire logic brownout_det,
  input wire logic brownout_rst_en,
  input wire logic wdog_fault,
  input wire logic ext_pin_in,
  input wire logic ext_pin_out,
  input wire logic ext_pin_oe,
  input wire logic cpu_nreset,
  input wire logic periph_nreset,
  input wire logic irq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // No source active, so a keyed command must be taken at once
  wire logic quiet = cpu_nreset && periph_nreset && !ext_pin_oe && ext_pin_in
    && !brownout_det && !wdog_fault && core_supply_ok;
  wire logic cmd_ok = reg_wr && reg_addr == 8'h00 && reg_wdata[31:24] == 8'hA5;
  wire logic st_rd = reg_rd && reg_addr == 8'h04;
  wire logic md_wr = reg_wr && reg_addr == 8'h08 && reg_wdata[31:24] == 8'hA5;

  a_supply_gate: assert property (!core_supply_ok |-> !cpu_nreset && !periph_nreset && ext_pin_oe)
    else $error("outputs not forced while supply low");
  a_pin_open_drain: assert property (ext_pin_oe |-> ext_pin_out == 1'h0)
    else $error("pin driven high");
  a_soft_cpu_span: assert property (quiet && cmd_ok && reg_wdata[0] |=>
    !cpu_nreset [*8] ##[1:6] cpu_nreset)
    else $error("software reset length wrong");
  a_bad_key: assert property (quiet && reg_wr && reg_addr == 8'h00 && reg_wdata[31:24] != 8'hA5
    |=> (cpu_nreset && periph_nreset && !ext_pin_oe) [*3])
    else $error("control write without password acted");
  a_periph_only: assert property (quiet && cmd_ok && reg_wdata[3:0] == 4'h4 |=>
    cpu_nreset && !periph_nreset)
    else $error("peripheral command wrong");
  a_read_clears: assert property (st_rd && ext_pin_in && !brownout_det ##2 st_rd && ext_pin_in
    |=> reg_rdata[1:0] == 2'h0)
    else $error("flags survive status read");
  a_pin_level: assert property ($stable(ext_pin_in) [*3] ##0 st_rd |=>
    reg_rdata[16] == $past(ext_pin_in))
    else $error("pin level bit wrong");
  a_mode_back: assert property (md_wr ##1 reg_rd && reg_addr == 8'h08 |=>
    reg_rdata == ($past(reg_wdata, 2) & 32'h0001_0F11))
    else $error("mode readback wrong");
  a_brown_hold: assert property ((brownout_rst_en && brownout_det) [*6] |->
    !cpu_nreset && !periph_nreset)
    else $error("brownout did not reset");
endmodule // sysrst_chk

bind sysrst_ctrl sysrst_chk #(.SLOW_DIV(SLOW_DIV), .STARTUP_SLOW(STARTUP_SLOW)) sysrst_chk_i (
  .sys_clk(sys_clk), .nrst(nrst), .core_supply_ok(core_supply_ok),
  .brownout_det(brownout_det), .brownout_rst_en(brownout_rst_en), .wdog_fault(wdog_fault),
  .ext_pin_in(ext_pin_in), .ext_pin_out(ext_pin_out), .ext_pin_oe(ext_pin_oe),
  .cpu_nreset(cpu_nreset), .periph_nreset(periph_nreset), .irq(irq), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ### sim/sysrst_pin_model.sv
// Shared reset line: pull-up, the device and an outside board
module sysrst_pin_model (
  input wire logic ext_pin_out,
  input wire logic ext_pin_oe,
  input wire logic hold_low,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up wins unless someone pulls down; board may hold past the pulse
  assign pin_level = !(ext_pin_oe && !ext_pin_out) && !hold_low;
endmodule // sysrst_pin_model

// ### sim/tb_system_reset_controller.sv
// Self-checking bench for the system reset controller
module tb_system_reset_controller;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] ex;
  } sysrst_row_t;
  logic sys_clk, nrst, core_supply_ok, brownout_det, brownout_rst_en, wdog_fault;
  logic ext_pin_in, ext_pin_out, ext_pin_oe, cpu_nreset, periph_nreset, irq;
  logic hold_low, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int err_total, n_compared, n, k;
  sysrst_row_t rows [6];

  // Slow tick every 4 system cycles keeps the run short
  sysrst_ctrl #(.SLOW_DIV(4), .STARTUP_SLOW(4)) sysrst_ctrl_i (
    .sys_clk(sys_clk), .nrst(nrst), .core_supply_ok(core_supply_ok),
    .brownout_det(brownout_det), .brownout_rst_en(brownout_rst_en), .wdog_fault(wdog_fault),
    .ext_pin_in(ext_pin_in), .ext_pin_out(ext_pin_out), .ext_pin_oe(ext_pin_oe),
    .cpu_nreset(cpu_nreset), .periph_nreset(periph_nreset), .irq(irq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sysrst_pin_model sysrst_pin_model_i (.ext_pin_out(ext_pin_out), .ext_pin_oe(ext_pin_oe),
    .hold_low(hold_low), .pin_level(ext_pin_in));

  // 100 ns clock
  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    n_compared++;
    if (g < lo || g > hi)
    begin
      err_total++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // Bus tasks are entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(posedge sys_clk);
    rv = reg_rdata;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // Sample on the falling edge so register updates have landed
  task automatic wait_rel;
    k = 0;
    while ((cpu_nreset & periph_nreset) !== 1'h1 && k < 400)
    begin
      @(negedge sys_clk);
      k++;
    end
    @(posedge sys_clk);
    chk({31'h0, cpu_nreset & periph_nreset}, 32'h0000_0001);
  endtask
  task automatic give_verdict;
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, far beyond the under one thousand cycles the run needs
  initial
  begin
    tick(20000);
    err_total++;
    give_verdict();
  end

  initial
  begin
    {nrst, brownout_det, brownout_rst_en, wdog_fault, hold_low, reg_wr, reg_rd} = 7'h00;
    core_supply_ok = 1'h1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    err_total = 0;
    n_compared = 0;
    rows[0] = '{8'h08, 32'hA501_0F11, 8'h08, 32'h0001_0F11};
    rows[1] = '{8'h08, 32'h3300_0000, 8'h08, 32'h0001_0F11};
    rows[2] = '{8'h08, 32'hA5FE_F0EE, 8'h08, 32'h0000_0000};
    rows[3] = '{8'h08, 32'hA500_0100, 8'h00, 32'h0000_0000};
    rows[4] = '{8'h0C, 32'h5A5A_5A5A, 8'h0C, 32'h0000_0000};
    rows[5] = '{8'h00, 32'h5A00_000D, 8'h08, 32'h0000_0100};
    tick(12);
    chk({30'h0, cpu_nreset, irq}, 32'h0000_0000);
    nrst <= 1'h1;
    wait_rel();
    rd(8'h04);
    chk(rv, 32'h0001_0000);
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      chk(rv, rows[i].ex);
    end
    // Pin pulse per length, user reset enabled but never entered
    for (int len = 0; len < 3; len++)
    begin
      wr(8'h08, {20'hA_5000, len[3:0], 8'h01});
      // One idle edge so the write strobe is not lowered and raised in one step
      tick(1);
      wr(8'h00, 32'hA500_0008);
      n = 0;
      k = 0;
      repeat (60)
      begin
        @(posedge sys_clk);
        n += (ext_pin_oe === 1'h1);
        k += (cpu_nreset !== 1'h1);
      end
      chk_rng(n, ((2 << len) - 1) * 4 + 1, (2 << len) * 4 + 1);
      chk_rng(k, 0, 0);
      rd(8'h04);
    end
    wr(8'h00, 32'hA500_0001);
    rd(8'h04);
    chk({rv[17], cpu_nreset, periph_nreset}, 3'h5);
    wr(8'h00, 32'hA500_0004);
    tick(3);
    chk({31'h0, periph_nreset}, 32'h0000_0001);
    wait_rel();
    rd(8'h04);
    chk(rv & 32'h0002_0700, 32'h0000_0300);
    // Board holds the line about ten slow ticks, a little longer than the eight-tick pulse
    hold_low <= 1'h1;
    tick(40);
    rd(8'h04);
    chk({rv[16], cpu_nreset, periph_nreset}, 3'h0);
    hold_low <= 1'h0;
    wait_rel();
    // Pin rise reaches a slow tick 3 to 6 cycles later, then five slow ticks
    chk_rng(k, 3 + 5 * 4 + 1, 6 + 5 * 4 + 1);
    rd(8'h04);
    chk(rv & 32'h0000_0700, 32'h0000_0400);
    wr(8'h00, 32'hA500_0004);
    tick(1);
    chk({cpu_nreset, periph_nreset}, 2'h2);
    wait_rel();
    rd(8'h04);
    chk(rv & 32'h0000_0700, 32'h0000_0400);
    wr(8'h08, 32'hA500_0010);
    hold_low <= 1'h1;
    tick(12);
    hold_low <= 1'h0;
    tick(4);
    chk({cpu_nreset, irq}, 2'h3);
    rd(8'h04);
    chk(rv[1:0], 2'h1);
    rd(8'h04);
    chk({rv[0], irq}, 2'h0);
    wr(8'h08, 32'hA501_0000);
    brownout_det <= 1'h1;
    tick(10);
    brownout_det <= 1'h0;
    tick(4);
    chk({cpu_nreset, irq}, 2'h3);
    rd(8'h04);
    chk(rv[1:0], 2'h2);
    rd(8'h04);
    chk({rv[1], irq}, 2'h0);
    brownout_rst_en <= 1'h1;
    tick(4);
    brownout_det <= 1'h1;
    n = 0;
    repeat (12)
    begin
      @(posedge sys_clk);
      n += (ext_pin_oe === 1'h1);
    end
    chk({cpu_nreset, periph_nreset, n > 0}, 3'h1);
    brownout_det <= 1'h0;
    wait_rel();
    chk_rng(k, 16, 26);
    rd(8'h04);
    chk(rv & 32'h0000_0700, 32'h0000_0500);
    // Watchdog fault in mid software reset takes over
    wr(8'h00, 32'hA500_0001);
    wdog_fault <= 1'h1;
    tick(1);
    wdog_fault <= 1'h0;
    wait_rel();
    rd(8'h04);
    chk(rv & 32'h0000_0700, 32'h0000_0200);
    // All three command bits at once
    wr(8'h00, 32'hA500_000D);
    tick(1);
    chk({cpu_nreset, periph_nreset, ext_pin_oe}, 3'h1);
    wait_rel();
    rd(8'h04);
    chk(rv & 32'h0000_0700, 32'h0000_0300);
    core_supply_ok <= 1'h0;
    #1;
    chk({cpu_nreset, periph_nreset, ext_pin_oe}, 3'h1);
    tick(8);
    core_supply_ok <= 1'h1;
    wait_rel();
    rd(8'h04);
    chk(rv & 32'h0000_0700, 32'h0000_0000);
    // Reset pulse in mid-run clears the mode register and holds the resets
    nrst <= 1'h0;
    tick(2);
    chk({30'h0, cpu_nreset, irq}, 32'h0000_0000);
    nrst <= 1'h1;
    wait_rel();
    rd(8'h08);
    chk(rv, 32'h0000_0000);
    give_verdict();
  end
endmodule // tb_system_reset_controller
